// ### logic/sar_consts.svh
// timing counts, register offsets and field positions for the sar link
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define SAR_CLK_PERIOD_NS 4
`define SAR_CSH_NORMAL_NS 150
`define SAR_CSH_LOWPWR_NS 500
`define SAR_BUSY_RISE_PGA_NS 100
`define SAR_BUSY_RISE_BYP_NS 30
`define SAR_CONV_PGA_NS 1550
`define SAR_CONV_BYP_NS 660
`define SAR_SCK_MIN_PERIOD_NS 20
`define SAR_CYC_NRM_BYP_NS 1110
`define SAR_CYC_NRM_BYP_TAG_NS 1170
`define SAR_CYC_NRM_PGA_NS 2070
`define SAR_CYC_NRM_PGA_TAG_NS 2190
`define SAR_CYC_LP_BYP_NS 1460
`define SAR_CYC_LP_BYP_TAG_NS 1520
`define SAR_CYC_LP_PGA_NS 2420
`define SAR_CYC_LP_PGA_TAG_NS 2540
`define SAR_CSH_NORMAL_CYC \
  ((`SAR_CSH_NORMAL_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_CSH_LOWPWR_CYC \
  ((`SAR_CSH_LOWPWR_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_BUSY_RISE_PGA_CYC (`SAR_BUSY_RISE_PGA_NS / `SAR_CLK_PERIOD_NS)
`define SAR_BUSY_RISE_BYP_CYC (`SAR_BUSY_RISE_BYP_NS / `SAR_CLK_PERIOD_NS)
`define SAR_CONV_PGA_CYC (`SAR_CONV_PGA_NS / `SAR_CLK_PERIOD_NS)
`define SAR_CONV_BYP_CYC (`SAR_CONV_BYP_NS / `SAR_CLK_PERIOD_NS)
`define SAR_SCK_MIN_HALF_CYC \
  ((`SAR_SCK_MIN_PERIOD_NS / 2 + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_SCK_HALF_CYC 8
`define SAR_SYNC_CYC 3
`define SAR_RESULT_BITS 14
`define SAR_TAG_BITS 6
`define SAR_FRAME_BITS 20
`define SAR_REG_CTRL 8'h00
`define SAR_REG_STATUS 8'h04
`define SAR_REG_RESULT 8'h08
`define SAR_CTRL_START 0
`define SAR_CTRL_LP 1
`define SAR_CTRL_BYP 2
`define SAR_CTRL_TAGS_LSB 3
`define SAR_CTRL_CHAN_LSB 6
`define SAR_CTRL_GAIN_LSB 9
`define SAR_STATUS_RUN 0
`define SAR_STATUS_DONE 1
`define SAR_RESULT_TAGS_LSB 16
`define SAR_CTRL_RESET 32'h00000000
`endif

// ### logic/sar_pkg.sv
// state types for both ends of the sar link
`default_nettype none
package sar_pkg;
  typedef enum logic [1:0] {DEV_IDLE, DEV_CONV, DEV_SHIFT} sar_dev_st_t;
  typedef enum logic [2:0]
  {
    HST_IDLE, HST_WAIT_HIGH, HST_START, HST_CONV, HST_LOW, HST_HIGH
  } sar_hst_st_t;
  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] sck_s;
    logic cs_d;
    logic sck_d;
    logic [2:0] ch_s1;
    logic [2:0] ch_s2;
    logic [2:0] gn_s1;
    logic [2:0] gn_s2;
    logic [1:0] lp_s;
    logic [1:0] byp_s;
    sar_dev_st_t st;
    logic [9:0] cnt;
    logic busy;
    logic sdo;
    logic oe;
    logic [19:0] sr;
    logic [2:0] ch_new;
    logic [2:0] ch_old;
    logic [2:0] gn_new;
    logic [2:0] gn_old;
    logic [2:0] ch_use;
    logic [2:0] gn_use;
    logic warm;
    logic take;
    logic ok;
    logic [15:0] acq_cnt;
    logic [15:0] acq;
  } sar_dev_t;
  typedef struct packed {
    logic lp;
    logic byp;
    logic [2:0] tags;
    logic [2:0] ch;
    logic [2:0] gn;
    logic go;
    logic run;
    logic done;
    logic [13:0] result;
    logic [5:0] tagv;
    logic [31:0] rdata;
    logic [1:0] busy_s;
    logic [1:0] sdo_s;
    sar_hst_st_t st;
    logic [9:0] cnt;
    logic [9:0] csh_cnt;
    logic [9:0] cyc_cnt;
    logic [4:0] idx;
    logic [19:0] frame;
    logic cs_n;
    logic sck;
  } sar_hst_t;
endpackage
`default_nettype wire

// ### logic/sar_link_if.sv
// pins between the converter end and the host controller end
`timescale 1ns/1ns
`default_nettype none
interface sar_link_if;
  logic cs_n;
  logic sck;
  logic low_power_select;
  logic pga_bypass;
  logic [2:0] channel_select_bits;
  logic [2:0] gain_select_bits;
  logic busy;
  logic sdo_o;
  logic sdo_oe;
  modport dev
  (
    input cs_n, sck, low_power_select, pga_bypass,
    input channel_select_bits, gain_select_bits,
    output busy, sdo_o, sdo_oe
  );
  modport host
  (
    output cs_n, sck, low_power_select, pga_bypass,
    output channel_select_bits, gain_select_bits,
    input busy, sdo_o, sdo_oe
  );
endinterface
`default_nettype wire

// ### logic/sar_adc_end.sv
// converter end: conversion timing and serial result shifter
`timescale 1ns/1ns
`default_nettype none
`include "sar_consts.svh"
module sar_adc_end
(
  input wire logic core_clk,
  input wire logic rst,
  sar_link_if.dev link,
  input wire logic [13:0] sample_code,
  output logic sample_take,
  output logic [2:0] sample_chan,
  output logic [2:0] sample_gain,
  output logic sample_ok,
  output logic [15:0] acq_cycles
);
  sar_pkg::sar_dev_t s;
  sar_pkg::sar_dev_t n;

  // busy is cut short by the pin synchroniser delay so the pin deadline holds
  function automatic logic [9:0] conv_len(input logic byp);
    conv_len = byp ? 10'(`SAR_CONV_BYP_CYC - `SAR_SYNC_CYC)
                   : 10'(`SAR_CONV_PGA_CYC - `SAR_SYNC_CYC);
  endfunction

  always_comb
  begin
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic [2:0] ch;
    logic [2:0] gn;
    cs_rise = 1'b0;
    cs_fall = 1'b0;
    sck_rise = 1'b0;
    ch = 3'h0;
    gn = 3'h0;
    n = s;
    n.take = 1'b0;
    n.cs_s = {s.cs_s[0], link.cs_n};
    n.sck_s = {s.sck_s[0], link.sck};
    n.ch_s1 = link.channel_select_bits;
    n.ch_s2 = s.ch_s1;
    n.gn_s1 = link.gain_select_bits;
    n.gn_s2 = s.gn_s1;
    n.lp_s = {s.lp_s[0], link.low_power_select};
    n.byp_s = {s.byp_s[0], link.pga_bypass};
    n.cs_d = s.cs_s[1];
    n.sck_d = s.sck_s[1];
    cs_rise = s.cs_s[1] & ~s.cs_d;
    cs_fall = ~s.cs_s[1] & s.cs_d;
    sck_rise = s.sck_s[1] & ~s.sck_d;
    if (s.cs_s[1] && s.acq_cnt != 16'hffff)
      n.acq_cnt = s.acq_cnt + 16'h1;
    if (cs_rise)
    begin
      n.acq_cnt = 16'h0;
      n.ch_old = s.ch_new;
      n.gn_old = s.gn_new;
      n.ch_new = s.ch_s2;
      n.gn_new = s.gn_s2;
      n.warm = 1'b1;
    end
    case (s.st)
      sar_pkg::DEV_CONV:
      begin
        n.cnt = s.cnt - 10'h1;
        if (s.cnt == 10'h1)
        begin
          n.busy = 1'b0;
          n.sdo = s.sr[19];
          n.st = sar_pkg::DEV_SHIFT;
        end
      end
      sar_pkg::DEV_SHIFT:
      begin
        if (cs_rise)
        begin
          n.oe = 1'b0;
          n.st = sar_pkg::DEV_IDLE;
        end
        else if (sck_rise)
        begin
          n.sr = {s.sr[18:0], 1'b0};
          n.sdo = s.sr[18];
        end
      end
      default:
      begin
        if (cs_rise)
          n.oe = 1'b0;
        if (cs_fall)
        begin
          ch = s.lp_s[1] ? s.ch_new : s.ch_old;
          gn = s.lp_s[1] ? s.gn_new : s.gn_old;
          n.ch_use = ch;
          n.gn_use = gn;
          n.take = 1'b1;
          n.oe = 1'b1;
          n.sdo = 1'b0;
          n.acq = s.acq_cnt;
          n.sr = {sample_code, ch, gn};
          n.ok = s.lp_s[1] | s.warm;
          n.busy = 1'b1;
          n.cnt = conv_len(s.byp_s[1]);
          n.st = sar_pkg::DEV_CONV;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.cs_s <= 2'h3;
      s.cs_d <= 1'b1;
      s.st <= sar_pkg::DEV_IDLE;
    end
    else
      s <= n;
  end

  assign link.busy = s.busy;
  assign link.sdo_o = s.sdo;
  assign link.sdo_oe = s.oe;
  assign sample_take = s.take;
  assign sample_chan = s.ch_use;
  assign sample_gain = s.gn_use;
  assign sample_ok = s.ok;
  assign acq_cycles = s.acq;
endmodule
`default_nettype wire

// ### logic/sar_host_end.sv
// host end: paces select and serial clock, gathers result and tags
`timescale 1ns/1ns
`default_nettype none
`include "sar_consts.svh"
module sar_host_end
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  sar_link_if.host link
);
  sar_pkg::sar_hst_t s;
  sar_pkg::sar_hst_t n;

  // tag requests above six are clamped; the device has no more tag bits
  function automatic logic [4:0] frame_len(input logic [2:0] tags);
    logic [2:0] t;
    t = (tags > 3'(`SAR_TAG_BITS)) ? 3'(`SAR_TAG_BITS) : tags;
    frame_len = 5'(`SAR_RESULT_BITS) + {2'h0, t};
  endfunction

  function automatic logic [9:0] high_need(input logic lp);
    high_need = lp ? 10'(`SAR_CSH_LOWPWR_CYC) : 10'(`SAR_CSH_NORMAL_CYC);
  endfunction

  // floor of the whole sample period, fall to fall, per mode and tags;
  // the bypass row with tags only covers channel tags, but six tags
  // at this serial clock rate take far longer than that floor anyway
  function automatic logic [9:0] period_need(input logic lp,
    input logic byp, input logic [2:0] tags);
    int ns;
    ns = 0;
    case ({lp, byp, tags != 3'h0})
      3'b000: ns = `SAR_CYC_NRM_PGA_NS;
      3'b001: ns = `SAR_CYC_NRM_PGA_TAG_NS;
      3'b010: ns = `SAR_CYC_NRM_BYP_NS;
      3'b011: ns = `SAR_CYC_NRM_BYP_TAG_NS;
      3'b100: ns = `SAR_CYC_LP_PGA_NS;
      3'b110: ns = `SAR_CYC_LP_BYP_NS;
      3'b111: ns = `SAR_CYC_LP_BYP_TAG_NS;
      default: ns = `SAR_CYC_LP_PGA_TAG_NS;
    endcase
    period_need = 10'((ns + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS);
  endfunction

  always_comb
  begin
    logic [4:0] pos;
    pos = 5'h0;
    n = s;
    n.rdata = 32'h0;
    n.busy_s = {s.busy_s[0], link.busy};
    n.sdo_s = {s.sdo_s[0], link.sdo_o};
    if (s.cs_n && s.csh_cnt != 10'h3ff)
      n.csh_cnt = s.csh_cnt + 10'h1;
    if (!s.cs_n)
      n.csh_cnt = 10'h0;
    // saturates so a long idle never wraps into a short period
    if (s.cyc_cnt != 10'h3ff)
      n.cyc_cnt = s.cyc_cnt + 10'h1;
    if (reg_rd)
    begin
      case (reg_addr)
        `SAR_REG_CTRL:
          n.rdata = {20'h0, s.gn, s.ch, s.tags, s.byp, s.lp, 1'b0};
        `SAR_REG_STATUS:
          n.rdata = {30'h0, s.done, s.run};
        `SAR_REG_RESULT:
          n.rdata = {10'h0, s.tagv, 2'h0, s.result};
        default:
          n.rdata = 32'h0;
      endcase
    end
    if (reg_wr && reg_addr == `SAR_REG_CTRL)
    begin
      n.lp = reg_wdata[`SAR_CTRL_LP];
      n.byp = reg_wdata[`SAR_CTRL_BYP];
      n.tags = reg_wdata[`SAR_CTRL_TAGS_LSB +: 3];
      n.ch = reg_wdata[`SAR_CTRL_CHAN_LSB +: 3];
      n.gn = reg_wdata[`SAR_CTRL_GAIN_LSB +: 3];
      if (reg_wdata[`SAR_CTRL_START])
        n.go = 1'b1;
    end
    if (reg_wr && reg_addr == `SAR_REG_STATUS &&
        reg_wdata[`SAR_STATUS_DONE])
      n.done = 1'b0;
    case (s.st)
      sar_pkg::HST_WAIT_HIGH:
      begin
        if (s.csh_cnt >= high_need(s.lp) &&
            s.cyc_cnt >= period_need(s.lp, s.byp, s.tags))
        begin
          n.cyc_cnt = 10'h0;
          n.cs_n = 1'b0;
          n.run = 1'b1;
          n.frame = 20'h0;
          n.st = sar_pkg::HST_START;
        end
      end
      sar_pkg::HST_START:
      begin
        if (s.busy_s[1])
          n.st = sar_pkg::HST_CONV;
      end
      sar_pkg::HST_CONV:
      begin
        // clock stays low until busy falls
        if (!s.busy_s[1])
        begin
          n.idx = 5'h0;
          n.cnt = 10'(`SAR_SCK_HALF_CYC);
          n.st = sar_pkg::HST_LOW;
        end
      end
      sar_pkg::HST_LOW:
      begin
        n.cnt = s.cnt - 10'h1;
        if (s.cnt == 10'h1)
        begin
          // bit taken before the next rise
          pos = 5'(`SAR_FRAME_BITS - 1) - s.idx;
          n.frame[pos] = s.sdo_s[1];
          n.sck = 1'b1;
          n.cnt = 10'(`SAR_SCK_HALF_CYC);
          n.st = sar_pkg::HST_HIGH;
        end
      end
      sar_pkg::HST_HIGH:
      begin
        n.cnt = s.cnt - 10'h1;
        if (s.cnt == 10'h1)
        begin
          n.sck = 1'b0;
          n.idx = s.idx + 5'h1;
          n.cnt = 10'(`SAR_SCK_HALF_CYC);
          n.st = sar_pkg::HST_LOW;
          if (s.idx + 5'h1 == frame_len(s.tags))
          begin
            n.cs_n = 1'b1;
            n.run = 1'b0;
            n.done = 1'b1;
            n.result = s.frame[19:6];
            n.tagv = s.frame[5:0];
            n.st = sar_pkg::HST_IDLE;
          end
        end
      end
      default:
      begin
        // pending start opens the next sample
        if (s.go)
        begin
          n.go = 1'b0;
          n.st = sar_pkg::HST_WAIT_HIGH;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.cs_n <= 1'b1;
      s.cyc_cnt <= 10'h3ff;
      s.st <= sar_pkg::HST_IDLE;
    end
    else
      s <= n;
  end

  assign reg_rdata = s.rdata;
  assign link.cs_n = s.cs_n;
  assign link.sck = s.sck;
  assign link.low_power_select = s.lp;
  assign link.pga_bypass = s.byp;
  // selects held from the control register
  assign link.channel_select_bits = s.ch;
  assign link.gain_select_bits = s.gn;
endmodule
`default_nettype wire

// ### test/sar_link_asserts.sv
// checker on the select, busy, serial clock and data wires
`timescale 1ns/1ns
`default_nettype none
module sar_link_asserts
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic low_power_select,
  input wire logic pga_bypass,
  input wire logic busy,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic [15:0] hi_cnt;
  logic cs_last;
  logic [15:0] cyc_cnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // saturates so a long idle never wraps into a short one
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hi_cnt <= 16'h0000;
    else if (!cs_n)
      hi_cnt <= 16'h0000;
    else if (hi_cnt != 16'hffff)
      hi_cnt <= hi_cnt + 16'h0001;
  end
  // the first fall after reset has no earlier sample to measure against
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_last <= 1'b1;
      cyc_cnt <= 16'hffff;
    end
    else
    begin
      cs_last <= cs_n;
      if (cs_last && !cs_n)
        cyc_cnt <= 16'h0001;
      else if (cyc_cnt != 16'hffff)
        cyc_cnt <= cyc_cnt + 16'h0001;
    end
  end
  cyc_normal_a: assert property ($fell(cs_n) && !low_power_select
    |-> cyc_cnt >= 16'h0116) else $error("sample period too short");
  cyc_lowpwr_a: assert property ($fell(cs_n) && low_power_select
    |-> cyc_cnt >= 16'h016d) else $error("low power period too short");
  csh_normal_a: assert property ($fell(cs_n) && !low_power_select
    |-> hi_cnt >= 16'h0026) else $error("select high too short");
  csh_lowpwr_a: assert property ($fell(cs_n) && low_power_select
    |-> hi_cnt >= 16'h007d) else $error("low power select too short");
  busy_byp_a: assert property ($fell(cs_n) && !busy && pga_bypass
    |-> ##[1:7] busy) else $error("busy late, amp bypassed");
  busy_amp_a: assert property ($fell(cs_n) && !busy
    |-> ##[1:25] busy) else $error("busy late");
  conv_byp_a: assert property ($rose(busy) && pga_bypass
    |-> ##[1:162] !busy) else $error("bypassed conversion too long");
  conv_amp_a: assert property ($rose(busy) |-> ##[1:384] !busy)
    else $error("conversion too long");
  sck_quiet_a: assert property (busy |-> !sck)
    else $error("serial clock moved in conversion");
  sdo_drive_a: assert property ($fell(cs_n) && !busy
    |-> ##[1:4] (sdo_oe && !sdo_o)) else $error("data not driven low");
  sdo_release_a: assert property ($rose(cs_n) |-> ##[1:4] !sdo_oe)
    else $error("data not released");
  sck_high_a: assert property ($rose(sck) |=> sck[*2])
    else $error("serial clock high too short");
endmodule
`default_nettype wire

// ### test/test_sar_adc_conversion_readout_timing.sv
// bench joining the host end and the converter end over the link
`timescale 1ns/1ns
`default_nettype none
module test_sar_adc_conversion_readout_timing;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [13:0] sample_code = 14'h0000;
  logic sample_take, sample_ok;
  logic [2:0] sample_chan, sample_gain;
  logic [15:0] acq_cycles;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int rises = 0;
  int takes = 0;
  sar_link_if link_bus();
  sar_host_end sar_host_end_inst (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link_bus));
  sar_adc_end sar_adc_end_inst (.core_clk(core_clk), .rst(rst),
    .link(link_bus), .sample_code(sample_code), .sample_take(sample_take),
    .sample_chan(sample_chan), .sample_gain(sample_gain),
    .sample_ok(sample_ok), .acq_cycles(acq_cycles));
  sar_link_asserts sar_link_asserts_inst (.core_clk(core_clk), .rst(rst),
    .cs_n(link_bus.cs_n), .sck(link_bus.sck),
    .low_power_select(link_bus.low_power_select),
    .pga_bypass(link_bus.pga_bypass), .busy(link_bus.busy),
    .sdo_o(link_bus.sdo_o), .sdo_oe(link_bus.sdo_oe));
  always #2 core_clk = ~core_clk;
  always @(posedge link_bus.sck)
    if (!link_bus.cs_n)
      rises++;
  always @(negedge link_bus.cs_n)
    rises = 0;
  // counted mid-cycle, where the one-cycle pulse has settled
  always @(negedge core_clk)
    if (sample_take === 1'b1)
      takes++;
  task close_out();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hung handshake ends here instead of running forever
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end
  task check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    q = reg_rdata;
    @(posedge core_clk);
  endtask
  function automatic logic [31:0] mk(input logic lp, byp,
    input logic [2:0] tg, ch, gn);
    mk = {20'h00000, gn, ch, tg, byp, lp, 1'b1};
  endfunction
  // one start, wait for done, clear it, then fetch the result
  task conv(input logic [31:0] c, input logic [13:0] code,
    input logic [5:0] tg);
    logic [31:0] st;
    logic [31:0] r;
    int i;
    st = 32'h00000000;
    takes = 0;
    sample_code <= code;
    wr(8'h00, c);
    for (i = 0; i < 1000 && st[1] !== 1'b1; i++)
      rd(8'h04, st);
    check("done", {31'h0, st[1]}, 32'h1);
    wr(8'h04, 32'h00000002);
    rd(8'h08, r);
    check("result", r, {10'h000, tg, 2'h0, code});
    check("sck rises", 32'(rises), 32'(14 + c[5:3]));
    check("samples", 32'(takes), 32'h1);
  endtask
  task test_lowpwr();
    conv(mk(1'b1, 1'b0, 3'h0, 3'h5, 3'h3), 14'h2a5c, 6'h00);
    check("first ok", {31'h0, sample_ok}, 32'h1);
    conv(mk(1'b1, 1'b0, 3'h6, 3'h5, 3'h3), 14'h15a3, 6'h2b);
    check("chan", {29'h0, sample_chan}, 32'h5);
    check("gain", {29'h0, sample_gain}, 32'h3);
    check("acq", {31'h0, acq_cycles >= 16'h007d}, 32'h1);
    conv(mk(1'b1, 1'b0, 3'h6, 3'h2, 3'h6), 14'h3fff, 6'h2b);
    conv(mk(1'b1, 1'b0, 3'h6, 3'h2, 3'h6), 14'h0001, 6'h16);
    $display("low power test over");
  endtask
  task test_normal();
    conv(mk(1'b0, 1'b1, 3'h6, 3'h1, 3'h2), 14'h0aaa, 6'h16);
    conv(mk(1'b0, 1'b1, 3'h6, 3'h1, 3'h2), 14'h2000, 6'h16);
    conv(mk(1'b0, 1'b1, 3'h3, 3'h1, 3'h2), 14'h1555, 6'h08);
    $display("normal test over");
  endtask
  task test_regs();
    logic [31:0] q;
    rd(8'h40, q);
    check("unmapped", q, 32'h0);
    rd(8'h04, q);
    check("done clear", {31'h0, q[1]}, 32'h0);
    check("run idle", {31'h0, q[0]}, 32'h0);
    rd(8'h00, q);
    check("ctrl", q, mk(1'b0, 1'b1, 3'h3, 3'h1, 3'h2) ^ 32'h1);
    $display("register test over");
  endtask
  // a reset in mid-run brings back the invalid first normal sample
  task test_reset();
    logic [31:0] q;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check("ok after reset", {31'h0, sample_ok}, 32'h0);
    rd(8'h00, q);
    check("ctrl after reset", q, 32'h0);
    conv(mk(1'b0, 1'b1, 3'h0, 3'h4, 3'h1), 14'h1234, 6'h00);
    check("first normal ok", {31'h0, sample_ok}, 32'h0);
    conv(mk(1'b0, 1'b1, 3'h6, 3'h4, 3'h1), 14'h0c3a, 6'h00);
    check("second normal ok", {31'h0, sample_ok}, 32'h1);
    $display("reset test over");
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (130) @(posedge core_clk);
    test_lowpwr();
    test_normal();
    test_regs();
    test_reset();
    close_out();
  end
endmodule
`default_nettype wire
